//--- core/chp_pkg.sv
// constants and types shared by the card end and the host end of the pin link
// assumes one 100 MHz clock on both ends; no software-visible registers
package chp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_PULSE_NS = 50;
    localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOST_STROBE_NS = 40;
    localparam int HOST_STROBE_CYCLES = (HOST_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CHP_MODE_MEM = 3'h1,
        CHP_MODE_IO  = 3'h2,
        CHP_MODE_IDE = 3'h4
    } chp_mode_t;

    typedef enum logic [2:0] {
        CHP_ST_INIT  = 3'h1,
        CHP_ST_READY = 3'h2,
        CHP_ST_BUSY  = 3'h4
    } chp_state_t;

    typedef enum logic [3:0] {
        CHP_DMA_IDLE  = 4'h1,
        CHP_DMA_REQ   = 4'h2,
        CHP_DMA_XFER  = 4'h4,
        CHP_DMA_ULTRA = 4'h8
    } chp_dma_t;

    typedef enum logic [2:0] {
        CHP_H_IDLE   = 3'h1,
        CHP_H_STROBE = 3'h2,
        CHP_H_DONE   = 3'h4
    } chp_hstate_t;

    // ------------------------------------------------------------
    // small helpers
    // ------------------------------------------------------------
    function automatic logic chp_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : chp_rise
endpackage : chp_pkg

//--- core/chp_link_if.sv
// pin-level link between host controller and storage card
// all pins are sampled as synchronous to the shared clock
`timescale 1ns/100ps
interface chp_link_if;
    logic io_write_strobe_n;
    logic output_enable_n;
    logic ide_mode_select_n;
    logic attr_select_n;
    logic card_reset;
    logic soft_reset;
    logic ready;
    logic input_acknowledge_n;
    logic dma_request;
    logic ultra_dma_active;
    logic [15:0] host_data;
    logic [15:0] card_data;
    logic card_data_oe;

    modport card (
        input io_write_strobe_n, output_enable_n, ide_mode_select_n, attr_select_n,
        input card_reset, soft_reset, ultra_dma_active, host_data,
        output ready, input_acknowledge_n, dma_request, card_data, card_data_oe
    );
    modport host (
        output io_write_strobe_n, output_enable_n, ide_mode_select_n, attr_select_n,
        output card_reset, soft_reset, ultra_dma_active, host_data,
        input ready, input_acknowledge_n, dma_request, card_data, card_data_oe
    );
endinterface : chp_link_if

//--- core/chp_card.sv
// card end: mode-dependent behaviour of the host-side control pins
// assumes host pins are synchronous to clk (write strobe still edge-detected, output enable sampled as a level)
`timescale 1ns/100ps
// Functional notes
// R1: io mode latches data on write rise
// R2: host negates write strobe before ultra dma
// R3: stop on write pin ends ultra burst
// R4: memory mode output enable drives read data
// R5: io mode output enable only reads registers
// R6: grounded mode select gives ide pin functions
// R7: memory mode ready high idle, low busy
// R8: ready low until init; host waits
// R9: reset held from power never stalls ready
// R10: io mode ready pin is low interrupt
// R11: ide mode interrupt active high on ready
// R12: attribute select picks common or attribute memory
// R13: host holds attribute select low in io
// R14: host acknowledges dma via attribute select pin
// R15: acknowledge ignored while no dma active
// R16: non-dma ide host ties acknowledge high
// R17: pc card modes reset while reset high
// R18: reset held from power: one reset only
// R19: soft reset bit also resets card
// R20: ide mode reset pin is active low
// R21: dma request held until acknowledge, then dropped
// R22: io read response asserts input acknowledge
// R23: host strobes and reset edge-detected internally; the code edge-detects only the write strobe and the reset pin
module chp_card
    import chp_pkg::*;
#(
    parameter int INIT_CNT = INIT_CYCLES,
    parameter int PULSE_CNT = IRQ_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    chp_link_if.card lnk,
    // user side
    input wire logic io_mode_cfg,
    input wire logic irq_level_mode,
    input wire logic irq_event,
    input wire logic busy_req,
    input wire logic dma_more,
    input wire logic [15:0] common_rd_data,
    input wire logic [15:0] attr_rd_data,
    output logic [15:0] io_wr_data,
    output logic io_wr_valid,
    output logic ultra_burst_stop,
    output logic dma_xfer,
    output logic attr_access,
    output logic [2:0] mode
);
    // ------------------------------------------------------------
    // input edge detection
    // ------------------------------------------------------------
    logic wr_prev, rst_prev;
    logic wr_rise, wr_fall;
    logic pin_reset, power_seen, next_power_seen;
    logic held_edge, next_held_edge;
    chp_mode_t cur_mode;

    // R6: mode select
    assign cur_mode = !lnk.ide_mode_select_n ? CHP_MODE_IDE : (io_mode_cfg ? CHP_MODE_IO : CHP_MODE_MEM);

    // R23: edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_prev <= 1'b1;
            rst_prev <= 1'b1;
        end else begin
            wr_prev <= lnk.io_write_strobe_n;
            rst_prev <= pin_reset;
        end
    end
    assign wr_rise = chp_rise(lnk.io_write_strobe_n, wr_prev);
    assign wr_fall = chp_rise(wr_prev, lnk.io_write_strobe_n);

    // ------------------------------------------------------------
    // reset handling
    // ------------------------------------------------------------
    logic card_rst;
    // R20: ide reset active low
    // R17: pc card reset active high
    assign pin_reset = (cur_mode == CHP_MODE_IDE) ? !lnk.card_reset : lnk.card_reset;
    // R9: a reset level held since power-up is ignored; only a fresh rise counts
    // R18: the power-up init is that single reset
    // R19: soft reset bit
    // a fresh reset keeps init pinned for as long as it is held, so ready never blips
    assign card_rst = (power_seen && pin_reset && (!rst_prev || held_edge)) || lnk.soft_reset;
    always_comb begin
        next_power_seen = power_seen;
        next_held_edge = held_edge;
        if (!pin_reset) begin
            next_power_seen = 1'b1;
            next_held_edge = 1'b0;
        end
        if (power_seen && pin_reset && !rst_prev) next_held_edge = 1'b1;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            power_seen <= 1'b0;
            held_edge <= 1'b0;
        end else begin
            power_seen <= next_power_seen;
            held_edge <= next_held_edge;
        end
    end

    // ------------------------------------------------------------
    // ready state machine
    // ------------------------------------------------------------
    chp_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [CNT_W-1:0] pcnt, next_pcnt;
    logic irq_hold, next_irq_hold;
    logic next_ready;
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            // R8: busy during init
            CHP_ST_INIT: begin
                if (cnt == CNT_W'(INIT_CNT - 1)) next_state = CHP_ST_READY;
                else next_cnt = cnt + 1'b1;
            end
            CHP_ST_READY: if (busy_req) next_state = CHP_ST_BUSY;
            CHP_ST_BUSY: if (!busy_req) next_state = CHP_ST_READY;
            default: next_state = CHP_ST_INIT;
        endcase
        if (card_rst) begin
            next_state = CHP_ST_INIT;
            next_cnt = '0;
        end
    end

    // interrupt: pulse stretcher or level, set wins over release
    always_comb begin
        next_pcnt = pcnt;
        next_irq_hold = irq_hold;
        if (pcnt != '0) next_pcnt = pcnt - 1'b1;
        if (!irq_event) next_irq_hold = 1'b0;
        if (irq_event && !irq_hold) begin
            next_irq_hold = 1'b1;
            next_pcnt = CNT_W'(PULSE_CNT);
        end
        if (card_rst) begin
            next_pcnt = '0;
            next_irq_hold = 1'b0;
        end
    end

    always_comb begin
        case (cur_mode)
            // R10: active-low interrupt in io mode
            CHP_MODE_IO: next_ready = (state == CHP_ST_INIT) ? 1'b0 :
                                      !(irq_level_mode ? irq_event : (next_pcnt != '0));
            // R11: active-high interrupt in ide mode
            CHP_MODE_IDE: next_ready = (state != CHP_ST_INIT) && irq_event;
            // R7: ready high when idle
            default: next_ready = (next_state == CHP_ST_READY);
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= CHP_ST_INIT;
            cnt <= '0;
            pcnt <= '0;
            irq_hold <= 1'b0;
            lnk.ready <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            pcnt <= next_pcnt;
            irq_hold <= next_irq_hold;
            lnk.ready <= next_ready;
        end
    end

    // ------------------------------------------------------------
    // data strobes and dma
    // ------------------------------------------------------------
    chp_dma_t dma, next_dma;
    logic next_wr_valid, next_stop, next_in_ack_n, next_oe, next_attr;
    logic [15:0] next_wr_data, next_rd;
    always_comb begin
        next_dma = dma;
        next_wr_valid = 1'b0;
        next_wr_data = io_wr_data;
        next_stop = 1'b0;
        next_oe = 1'b0;
        next_rd = '0;
        next_in_ack_n = 1'b1;
        next_attr = attr_access;
        // R1: latch on trailing edge
        if (wr_rise && cur_mode != CHP_MODE_MEM && dma != CHP_DMA_ULTRA) begin
            next_wr_valid = 1'b1;
            next_wr_data = lnk.host_data;
        end
        if (!lnk.output_enable_n && cur_mode != CHP_MODE_IDE) begin
            // R12: attribute select decode
            next_attr = !lnk.attr_select_n;
            // R4: memory read of common or attribute space
            if (cur_mode == CHP_MODE_MEM) begin
                next_oe = 1'b1;
                next_rd = lnk.attr_select_n ? common_rd_data : attr_rd_data;
            // R5: io mode only attribute registers
            end else if (!lnk.attr_select_n) begin
                next_oe = 1'b1;
                next_rd = attr_rd_data;
            end
        end
        // R22: acknowledge io read response
        if (cur_mode == CHP_MODE_IO && !lnk.attr_select_n && !lnk.output_enable_n && state != CHP_ST_INIT)
            next_in_ack_n = 1'b0;
        case (dma)
            CHP_DMA_IDLE: if (cur_mode == CHP_MODE_IDE && dma_more) next_dma = CHP_DMA_REQ;
            // R21: hold request until acknowledge
            // R15: acknowledge only seen once requested
            CHP_DMA_REQ: if (!lnk.attr_select_n)
                next_dma = lnk.ultra_dma_active ? CHP_DMA_ULTRA : CHP_DMA_XFER;
            CHP_DMA_XFER: if (lnk.attr_select_n) next_dma = dma_more ? CHP_DMA_REQ : CHP_DMA_IDLE;
            // R3: stop ends burst
            CHP_DMA_ULTRA: if (wr_fall || lnk.attr_select_n) begin
                next_stop = wr_fall;
                next_dma = CHP_DMA_IDLE;
            end
            default: next_dma = CHP_DMA_IDLE;
        endcase
        if (card_rst || cur_mode != CHP_MODE_IDE) next_dma = CHP_DMA_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dma <= CHP_DMA_IDLE;
            io_wr_valid <= 1'b0;
            io_wr_data <= 16'h0000;
            ultra_burst_stop <= 1'b0;
            attr_access <= 1'b0;
            dma_xfer <= 1'b0;
            mode <= CHP_MODE_MEM;
            lnk.card_data <= 16'h0000;
            lnk.card_data_oe <= 1'b0;
            lnk.input_acknowledge_n <= 1'b1;
            lnk.dma_request <= 1'b0;
        end else begin
            dma <= next_dma;
            io_wr_valid <= next_wr_valid;
            io_wr_data <= next_wr_data;
            ultra_burst_stop <= next_stop;
            attr_access <= next_attr;
            dma_xfer <= (next_dma == CHP_DMA_XFER) || (next_dma == CHP_DMA_ULTRA);
            mode <= cur_mode;
            lnk.card_data <= next_rd;
            lnk.card_data_oe <= next_oe;
            lnk.input_acknowledge_n <= next_in_ack_n;
            lnk.dma_request <= (next_dma == CHP_DMA_REQ);
        end
    end
endmodule : chp_card

//--- core/chp_host.sv
// host end: drives mode, reset and strobes toward the card
// assumes the card end shares clk; one request at a time
`timescale 1ns/100ps
module chp_host
    import chp_pkg::*;
#(
    parameter int STROBE_CNT = HOST_STROBE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    chp_link_if.host lnk,
    // user side
    input wire logic ide_mode,
    input wire logic dma_capable,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_attr,
    input wire logic [15:0] req_data,
    input wire logic card_reset_req,
    output logic req_ready,
    output logic [15:0] rsp_data,
    output logic rsp_valid
);
    chp_hstate_t st, next_st;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic wr_n, next_wr_n, oe_n, next_oe_n, reg_n, next_reg_n;
    logic [15:0] next_rsp;
    logic next_rsp_valid, next_req_ready;
    logic w_lat, next_w_lat;

    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_wr_n = 1'b1;
        next_oe_n = 1'b1;
        next_reg_n = reg_n;
        next_rsp = rsp_data;
        next_rsp_valid = 1'b0;
        next_w_lat = w_lat;
        case (st)
            // R8: no access until ready
            CHP_H_IDLE: if (req_valid && req_ready) begin
                next_st = CHP_H_STROBE;
                next_cnt = '0;
                next_w_lat = req_write;
                // R13: attribute select low for io
                next_reg_n = !req_attr;
                next_wr_n = !req_write;
                next_oe_n = req_write;
            end else if (!ide_mode || dma_capable) begin
                next_reg_n = 1'b1;
            end
            CHP_H_STROBE: begin
                next_wr_n = !w_lat;
                next_oe_n = w_lat;
                if (cnt == CNT_W'(STROBE_CNT - 1)) begin
                    // R1: rising write edge ends strobe
                    next_wr_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_rsp = lnk.card_data;
                    next_rsp_valid = !w_lat;
                    next_st = CHP_H_DONE;
                end else next_cnt = cnt + 1'b1;
            end
            CHP_H_DONE: next_st = CHP_H_IDLE;
            default: next_st = CHP_H_IDLE;
        endcase
        // R14: acknowledge a dma request
        if (ide_mode && dma_capable && st == CHP_H_IDLE) next_reg_n = !lnk.dma_request;
        // R16: non-dma ide host holds it high
        if (ide_mode && !dma_capable) next_reg_n = 1'b1;
        // R2: strobe negated in ultra dma
        next_req_ready = (next_st == CHP_H_IDLE) && lnk.ready && !ide_mode;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= CHP_H_IDLE;
            cnt <= '0;
            wr_n <= 1'b1;
            oe_n <= 1'b1;
            reg_n <= 1'b1;
            w_lat <= 1'b0;
            rsp_data <= 16'h0000;
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            wr_n <= next_wr_n;
            oe_n <= next_oe_n;
            reg_n <= next_reg_n;
            w_lat <= next_w_lat;
            rsp_data <= next_rsp;
            rsp_valid <= next_rsp_valid;
            req_ready <= next_req_ready;
        end
    end

    assign lnk.io_write_strobe_n = wr_n;
    // R6: mode select grounded for ide
    assign lnk.output_enable_n = oe_n;
    assign lnk.ide_mode_select_n = !ide_mode;
    assign lnk.attr_select_n = reg_n;
    // R20: ide reset active low
    assign lnk.card_reset = ide_mode ? !card_reset_req : card_reset_req;
    assign lnk.soft_reset = 1'b0;
    assign lnk.ultra_dma_active = 1'b0;
    assign lnk.host_data = req_data;
endmodule : chp_host

//--- verif/chp_link_asserts.sv
// checker for the host-card pin link, fed from the link interface signals
// assumes one shared clock and the synchronous active-high reset of both ends
`timescale 1ns/100ps
module chp_link_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link pins
    input wire logic io_write_strobe_n,
    input wire logic output_enable_n,
    input wire logic ide_mode_select_n,
    input wire logic attr_select_n,
    input wire logic card_reset,
    input wire logic ready,
    input wire logic input_acknowledge_n,
    input wire logic dma_request,
    input wire logic card_data_oe
);
    // ------------------------------------------------------------
    // pin relations
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_init_quiet;
        $fell(rst) |-> (!ready && io_write_strobe_n && output_enable_n) [*4];
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("link active during init");

    property p_oe_data;
        ide_mode_select_n && !output_enable_n && !attr_select_n |=> card_data_oe;
    endproperty
    a_oe_data: assert property (p_oe_data) else $error("no read data on output enable");

    property p_oe_off;
        ide_mode_select_n && output_enable_n |=> !card_data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("read data without strobe");

    property p_input_acknowledge_n_off;
        output_enable_n |=> input_acknowledge_n;
    endproperty
    a_input_acknowledge_n_off: assert property (p_input_acknowledge_n_off) else $error("input acknowledge without read");

    property p_wr_len;
        $fell(io_write_strobe_n) |-> !io_write_strobe_n [*4] ##1 io_write_strobe_n;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong");

    property p_oe_len;
        $fell(output_enable_n) |-> !output_enable_n [*4] ##1 output_enable_n;
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("read strobe width wrong");

    property p_dma_hold;
        !ide_mode_select_n && dma_request && attr_select_n |=> dma_request;
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped early");

    property p_dma_drop;
        !ide_mode_select_n && dma_request && !attr_select_n |=> !dma_request;
    endproperty
    a_dma_drop: assert property (p_dma_drop) else $error("dma request kept after ack");

    property p_no_dma_pc;
        ide_mode_select_n [*4] |-> !dma_request;
    endproperty
    a_no_dma_pc: assert property (p_no_dma_pc) else $error("dma request outside ide");

    property p_pin_rst;
        ide_mode_select_n && $rose(card_reset) |-> ##[1:4] (!ready [*4]);
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");
endmodule : chp_link_asserts

//--- verif/card_host_pin_behaviour_tb.sv
// self-checking bench: host end and card end joined by the pin link
// assumes package defaults for pulse and strobe widths, shortened init
`timescale 1ns/100ps
module card_host_pin_behaviour_tb;
    import chp_pkg::*;
    // ------------------------------------------------------------
    // stimulus and instances
    // ------------------------------------------------------------
    localparam int INIT = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic io_mode_cfg = 1'b0, irq_level_mode = 1'b0, irq_event = 1'b0, busy_req = 1'b0, dma_more = 1'b0;
    logic [15:0] common_rd_data = 16'hA5C3;
    logic [15:0] attr_rd_data = 16'h5A3C;
    logic [15:0] req_data = 16'h0000;
    logic [15:0] io_wr_data, rsp_data;
    logic io_wr_valid, ultra_burst_stop, dma_xfer, attr_access, req_ready, rsp_valid;
    logic [2:0] mode;
    logic ide_mode = 1'b0, dma_capable = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_attr = 1'b0;
    logic card_reset_req = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;
    int n;

    always #5 clk = ~clk;

    chp_link_if lnk ();

    chp_card #(.INIT_CNT(INIT)) chp_card_i (.clk(clk), .rst(rst), .lnk(lnk), .io_mode_cfg(io_mode_cfg),
        .irq_level_mode(irq_level_mode), .irq_event(irq_event), .busy_req(busy_req), .dma_more(dma_more),
        .common_rd_data(common_rd_data), .attr_rd_data(attr_rd_data), .io_wr_data(io_wr_data),
        .io_wr_valid(io_wr_valid), .ultra_burst_stop(ultra_burst_stop), .dma_xfer(dma_xfer),
        .attr_access(attr_access), .mode(mode));

    chp_host chp_host_i (.clk(clk), .rst(rst), .lnk(lnk), .ide_mode(ide_mode), .dma_capable(dma_capable),
        .req_valid(req_valid), .req_write(req_write), .req_attr(req_attr), .req_data(req_data),
        .card_reset_req(card_reset_req), .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid));

    chp_link_asserts chp_link_asserts_i (.clk(clk), .rst(rst), .io_write_strobe_n(lnk.io_write_strobe_n),
        .output_enable_n(lnk.output_enable_n), .ide_mode_select_n(lnk.ide_mode_select_n),
        .attr_select_n(lnk.attr_select_n), .card_reset(lnk.card_reset), .ready(lnk.ready),
        .input_acknowledge_n(lnk.input_acknowledge_n),
        .dma_request(lnk.dma_request), .card_data_oe(lnk.card_data_oe));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic sel(input int k);
        case (k)
            0: return req_ready;
            1: return rsp_valid;
            2: return io_wr_valid;
            3: return lnk.ready;
            4: return !lnk.ready;
            5: return lnk.dma_request;
            6: return dma_xfer;
            7: return mode === CHP_MODE_IDE;
            default: return !lnk.dma_request;
        endcase
    endfunction : sel

    // bounded wait; n holds the cycles spent
    task automatic wt(input int k, input int lim);
        n = 0;
        while (sel(k) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0000, sel(k)}, 16'h0001);
        if (sel(k) !== 1'b1) begin
            end_sim();
        end
    endtask : wt

    task automatic xfer(input logic w, input logic a, input logic [15:0] d);
        wt(0, 200);
        req_valid = 1'b1;
        req_write = w;
        req_attr = a;
        req_data = d;
        @(negedge clk);
        req_valid = 1'b0;
    endtask : xfer

    task automatic rd(input logic a, input logic [15:0] exp);
        xfer(1'b0, a, 16'h0000);
        wt(1, 20);
        chk(rsp_data, exp);
    endtask : rd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_mem;
        wt(3, INIT + 20);
        chk(16'(n >= INIT - 1), 16'h0001);
        chk({13'h0000, mode}, {13'h0000, CHP_MODE_MEM});
        rd(1'b0, 16'hA5C3);
        rd(1'b1, 16'h5A3C);
        chk({15'h0000, attr_access}, 16'h0001);
        // writes strobe into nothing here
        xfer(1'b1, 1'b0, 16'h1234);
        n = 0;
        repeat (12) begin
            @(negedge clk);
            n += int'(io_wr_valid !== 1'b0);
        end
        chk(16'(n), 16'h0000);
        busy_req = 1'b1;
        wt(4, 5);
        busy_req = 1'b0;
        wt(3, 5);
        $display("memory mode done");
    endtask : t_mem

    task automatic t_io;
        logic [15:0] wd [3];
        wd = '{16'hBEEF, 16'h0000, 16'hFFFF};
        io_mode_cfg = 1'b1;
        repeat (3) @(negedge clk);
        chk({13'h0000, mode}, {13'h0000, CHP_MODE_IO});
        foreach (wd[i]) begin
            xfer(1'b1, 1'b1, wd[i]);
            chk({15'h0000, lnk.attr_select_n}, 16'h0000);
            wt(2, 20);
            chk(io_wr_data, wd[i]);
        end
        xfer(1'b0, 1'b1, 16'h0000);
        @(negedge clk);
        chk({15'h0000, lnk.input_acknowledge_n}, 16'h0000);
        wt(1, 20);
        chk(rsp_data, 16'h5A3C);
        rd(1'b0, 16'h0000);
        irq_event = 1'b1;
        wt(4, 5);
        wt(3, 20);
        chk(16'(n), 16'(IRQ_PULSE_CYCLES));
        irq_event = 1'b0;
        irq_level_mode = 1'b1;
        @(negedge clk);
        irq_event = 1'b1;
        wt(4, 5);
        repeat (10) @(negedge clk);
        chk({15'h0000, lnk.ready}, 16'h0000);
        irq_event = 1'b0;
        wt(3, 5);
        $display("io mode done");
    endtask : t_io

    task automatic t_ide;
        ide_mode = 1'b1;
        wt(7, 10);
        chk({15'h0000, lnk.attr_select_n}, 16'h0001);
        dma_capable = 1'b1;
        irq_event = 1'b1;
        wt(3, 5);
        irq_event = 1'b0;
        wt(4, 5);
        dma_more = 1'b1;
        wt(5, 10);
        wt(6, 20);
        dma_more = 1'b0;
        wt(8, 40);
        repeat (3) @(negedge clk);
        chk({14'h0000, lnk.dma_request, dma_xfer}, 16'h0000);
        chk({15'h0000, ultra_burst_stop}, 16'h0000);
        ide_mode = 1'b0;
        io_mode_cfg = 1'b0;
        wt(3, INIT + 20);
        $display("ide mode done");
    endtask : t_ide

    task automatic t_rst;
        card_reset_req = 1'b1;
        wt(4, 10);
        repeat (3) @(negedge clk);
        card_reset_req = 1'b0;
        wt(3, INIT + 20);
        chk(16'(n >= INIT - 1), 16'h0001);
        rd(1'b0, 16'hA5C3);
        $display("pin reset done");
    endtask : t_rst

    // reset pin held high from power-up: one init only
    task automatic t_pwr;
        card_reset_req = 1'b1;
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        wt(3, INIT + 20);
        chk(16'(n >= INIT - 1), 16'h0001);
        card_reset_req = 1'b0;
        @(negedge clk);
        chk({15'h0000, lnk.ready}, 16'h0001);
        rd(1'b0, 16'hA5C3);
        $display("power-up reset done");
    endtask : t_pwr

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_mem();
        t_io();
        t_ide();
        t_rst();
        t_pwr();
        end_sim();
    end
endmodule : card_host_pin_behaviour_tb
